// ==== core/mies_pkg.sv ====
// constants and types for the instruction subset executor
package mies_pkg;
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned PC_W = 9;
  localparam int unsigned STACK_DEPTH = 2;
  localparam int unsigned FILE_COUNT = 32;
  localparam int unsigned CARRY_BIT = 0;
  localparam int unsigned DEST_BIT = 5;
  localparam logic [INSN_W-1:0] OP_NOP = 12'h000;
  localparam logic [INSN_W-1:0] OP_CFG_LOAD = 12'h002;
  localparam logic [6:0] OP_MOVE_PFX = 7'h01;
  localparam logic [3:0] OP_LITRET_PFX = 4'h8;
  localparam logic [5:0] OP_ROTL_PFX = 6'h0d;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
  localparam logic [DATA_W-1:0] CFG_RST = 8'hff;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
  localparam logic [PC_W-1:0] PC_RST = 9'h1ff;
  localparam logic [PC_W-1:0] RST_RET_ADDR = 9'h000;
  localparam int unsigned LITRET_CYCLES = 2;
  typedef enum logic [5:0] {
    MIES_OP_NOP = 6'b000001,
    MIES_OP_MOVE = 6'b000010,
    MIES_OP_CFG = 6'b000100,
    MIES_OP_LITRET = 6'b001000,
    MIES_OP_ROTL = 6'b010000,
    MIES_OP_OTHER = 6'b100000
  } mies_op_type;
endpackage

// ==== core/mies_dec_if.sv ====
// decoded instruction fields shared between decoder and executor
`timescale 1ns/100ps
`default_nettype none
interface mies_dec_if;
  import mies_pkg::*;
  mies_op_type op;
  logic [FADDR_W-1:0] faddr;
  logic dest_file;
  logic [DATA_W-1:0] literal;
  modport dec(output op, faddr, dest_file, literal);
  modport exe(input op, faddr, dest_file, literal);
endinterface
`default_nettype wire

// ==== core/mies_decoder.sv ====
// pattern decoder for the supported instruction words
`timescale 1ns/100ps
`default_nettype none
module mies_decoder (
  input wire logic [mies_pkg::INSN_W-1:0] i_insn,
  mies_dec_if.dec dec
);
  import mies_pkg::*;

  always_comb begin
    dec.faddr = i_insn[FADDR_W-1:0];
    dec.dest_file = i_insn[DEST_BIT];
    dec.literal = i_insn[DATA_W-1:0];
    if (i_insn == OP_NOP) begin
      dec.op = MIES_OP_NOP;
    end else if (i_insn == OP_CFG_LOAD) begin
      dec.op = MIES_OP_CFG;
    end else if (i_insn[11:5] == OP_MOVE_PFX) begin
      dec.op = MIES_OP_MOVE;
    end else if (i_insn[11:8] == OP_LITRET_PFX) begin
      dec.op = MIES_OP_LITRET;
    end else if (i_insn[11:6] == OP_ROTL_PFX) begin
      dec.op = MIES_OP_ROTL;
    end else begin
      dec.op = MIES_OP_OTHER;
    end
  end
endmodule
`default_nettype wire

// ==== core/mies_core.sv ====
// execution core for a subset of a 12-bit-opcode 8-bit instruction set
`timescale 1ns/100ps
`default_nettype none
module mies_core #(
  parameter int unsigned STACK_DEPTH_P = mies_pkg::STACK_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [mies_pkg::INSN_W-1:0] i_insn,
  input wire logic i_push_valid,
  input wire logic [mies_pkg::PC_W-1:0] i_push_addr,
  output logic [mies_pkg::PC_W-1:0] o_pc,
  output logic o_fetch_discard,
  output logic [mies_pkg::DATA_W-1:0] o_acc,
  output logic [mies_pkg::DATA_W-1:0] o_cfg,
  output logic [mies_pkg::DATA_W-1:0] o_status,
  output logic o_unsupported
);
  import mies_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (STACK_DEPTH_P < 1 || STACK_DEPTH_P > 8) begin : g_bad_depth
    $error("stack depth out of range");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  mies_dec_if dec_bus ();

  mies_decoder mies_decoder_i (
    .i_insn(i_insn),
    .dec(dec_bus.dec)
  );

  function automatic logic [DATA_W:0] rotl(input logic [DATA_W-1:0] v,
                                           input logic c);
    rotl = {v, c};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] file_q [FILE_COUNT];
  logic [DATA_W-1:0] file_d [FILE_COUNT];
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] cfg_d;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic discard_q;
  logic discard_d;
  logic unsup_q;
  logic unsup_d;
  logic [PC_W-1:0] stack_q [STACK_DEPTH_P];
  logic [PC_W-1:0] stack_d [STACK_DEPTH_P];
  logic [DATA_W:0] rot;
  logic exec_ok;
  logic do_move;
  logic do_cfg;
  logic do_litret;
  logic do_rotl;
  logic do_other;

  // ----------------------------------------------------------------
  // execute strobes
  // ----------------------------------------------------------------
  // the word fetched behind a literal return is dropped
  assign exec_ok = !discard_q;
  assign do_move = exec_ok && (dec_bus.op == MIES_OP_MOVE);
  assign do_cfg = exec_ok && (dec_bus.op == MIES_OP_CFG);
  assign do_litret = exec_ok && (dec_bus.op == MIES_OP_LITRET);
  assign do_rotl = exec_ok && (dec_bus.op == MIES_OP_ROTL);
  assign do_other = exec_ok && (dec_bus.op == MIES_OP_OTHER);
  assign rot = rotl(file_q[dec_bus.faddr], status_q[CARRY_BIT]);

  // ----------------------------------------------------------------
  // file registers
  // ----------------------------------------------------------------
  always_comb begin
    file_d = file_q;
    if (do_move) begin
      file_d[dec_bus.faddr] = acc_q;
    end else if (do_rotl && dec_bus.dest_file) begin
      file_d[dec_bus.faddr] = rot[DATA_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < FILE_COUNT; i++) begin
        file_q[i] <= FILE_RST;
      end
    end else begin
      file_q <= file_d;
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    if (do_litret) begin
      acc_d = dec_bus.literal;
    end else if (do_rotl && !dec_bus.dest_file) begin
      acc_d = rot[DATA_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      acc_q <= ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------------------------------
  // prescaler configuration
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    if (do_cfg) begin
      cfg_d = acc_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // status, carry only
  // ----------------------------------------------------------------
  always_comb begin
    status_d = status_q;
    if (do_rotl) begin
      status_d[CARRY_BIT] = rot[DATA_W];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // program counter and fetch drop
  // ----------------------------------------------------------------
  always_comb begin
    pc_d = pc_q + 9'h001;
    discard_d = 1'b0;
    if (do_litret) begin
      pc_d = stack_q[0];
      discard_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pc_q <= PC_RST;
      discard_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      discard_q <= discard_d;
    end
  end

  // ----------------------------------------------------------------
  // unsupported words, run as no-ops
  // ----------------------------------------------------------------
  always_comb begin
    unsup_d = do_other;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      unsup_q <= 1'b0;
    end else begin
      unsup_q <= unsup_d;
    end
  end

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  always_comb begin
    stack_d = stack_q;
    if (i_push_valid) begin
      for (int i = STACK_DEPTH_P - 1; i > 0; i--) begin
        stack_d[i] = stack_q[i-1];
      end
      stack_d[0] = i_push_addr;
    end
    // a pop in the same cycle overrides the pushed entry
    if (do_litret) begin
      for (int i = 0; i < STACK_DEPTH_P - 1; i++) begin
        stack_d[i] = stack_q[i+1];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < STACK_DEPTH_P; i++) begin
        stack_q[i] <= RST_RET_ADDR;
      end
    end else begin
      stack_q <= stack_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_pc = pc_q;
  assign o_fetch_discard = discard_q;
  assign o_acc = acc_q;
  assign o_cfg = cfg_q;
  assign o_status = status_q;
  assign o_unsupported = unsup_q;
endmodule
`default_nettype wire

// ==== tb/mies_pmem.sv ====
// program memory model feeding instruction words
`timescale 1ns/100ps
`default_nettype none
module mies_pmem (
  input wire logic i_ref_clk,
  input wire logic [8:0] i_addr,
  output logic [11:0] o_word
);
  logic [11:0] mem [512];
  always @(negedge i_ref_clk) o_word <= mem[i_addr];
endmodule
`default_nettype wire

// ==== tb/mies_core_asserts.sv ====
// port checks for the executor
`timescale 1ns/100ps
`default_nettype none
module mies_core_asserts (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_insn,
  input wire logic o_fetch_discard,
  input wire logic [8:0] o_pc,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_cfg,
  input wire logic [7:0] o_status
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic ex = !o_fetch_discard;
  a_move_quiet: assert property (ex && i_insn[11:5] == 7'h01
    |=> $stable(o_status) && $stable(o_acc)) else $error("move");
  a_cfg_load: assert property (ex && i_insn == 12'h002
    |=> o_cfg == $past(o_acc)) else $error("cfg");
  a_litret_acc: assert property (ex && i_insn[11:8] == 4'h8
    |=> o_acc == $past(i_insn[7:0]) && o_fetch_discard) else $error("ret");
  a_nop_quiet: assert property (ex && i_insn == 12'h000
    |=> $stable(o_acc) && o_pc == $past(o_pc) + 9'h001) else $error("nop");
  a_rotl_flags: assert property (ex && i_insn[11:6] == 6'h0d
    |=> o_status[7:1] == $past(o_status[7:1])) else $error("flags");
  a_rotl_acc: assert property (ex && i_insn[11:5] == 7'h1a
    |=> o_acc[0] == $past(o_status[0])) else $error("rotl");
  a_rotl_file: assert property (ex && i_insn[11:5] == 7'h1b
    |=> $stable(o_acc)) else $error("rotf");
  a_one_cycle: assert property (ex && i_insn[11:8] != 4'h8
    |=> !o_fetch_discard) else $error("cyc");
endmodule
`default_nettype wire

// ==== tb/mies_core_tb.sv ====
// self-checking bench for the executor
`timescale 1ns/100ps
`default_nettype none
module mies_core_tb;
  logic i_ref_clk = 0, i_sys_rst = 1, i_push_valid = 0, c, dc;
  logic [8:0] i_push_addr = 0, o_pc, pc, a, b, stk [2];
  logic [11:0] i_insn, w;
  logic o_fetch_discard, o_unsupported, u;
  logic [7:0] o_acc, o_cfg, o_status, acc, cfg, k, f [32];
  logic [4:0] r;
  logic [34:0] q [$];
  int mismatches = 0, comparisons = 0;
  mies_core mies_core_i (.i_ref_clk, .i_sys_rst, .i_insn, .i_push_valid,
    .i_push_addr, .o_pc, .o_fetch_discard, .o_acc, .o_cfg, .o_status,
    .o_unsupported);
  mies_pmem mies_pmem_i (.i_ref_clk, .i_addr(o_pc), .o_word(i_insn));
  initial forever #20 i_ref_clk = ~i_ref_clk;
  task automatic check(input logic [34:0] s, e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic put(input int n, input logic [11:0] v);
    mies_pmem_i.mem[n] = v;
  endtask
  always @(posedge i_ref_clk) if (!i_sys_rst) begin
    w = mies_pmem_i.mem[pc];
    k = {f[w[4:0]][6:0], c};
    u = 0;
    if (i_push_valid) {stk[1], stk[0]} = {stk[0], i_push_addr};
    pc++;
    if (dc) dc = 0;
    else if (w == 12'h002) cfg = acc;
    else if (w[11:5] == 7'h01) f[w[4:0]] = acc;
    else if (w[11:8] == 4'h8) begin
      {acc, pc, stk[0], dc} = {w[7:0], stk[0], stk[1], 1'b1};
    end else if (w[11:6] == 6'h0d) begin
      c = f[w[4:0]][7];
      if (w[5]) f[w[4:0]] = k;
      else acc = k;
    end else if (w != 12'h000) u = 1;
    q.push_back({pc, acc, cfg, 7'h0c, c, dc, u});
  end
  always @(negedge i_ref_clk) if (q.size() > 0)
    check({o_pc, o_acc, o_cfg, o_status, o_fetch_discard, o_unsupported},
      q.pop_front());
  initial begin
    void'($urandom(32'hd5ff34f1));
    repeat (3) begin
      @(negedge i_ref_clk) i_sys_rst = 1;
      {acc, cfg, pc, c, dc} = {8'h00, 8'hff, 9'h1ff, 2'b00};
      q.delete();
      foreach (f[n]) f[n] = 8'h00;
      a = 9'h100 + 9'($urandom % 120);
      b = 9'h080 + 9'($urandom % 120);
      r = 5'($urandom);
      for (int n = 0; n < 512; n++) put(n, 12'h000);
      put(3, {4'h8, 8'($urandom)});
      put(b + 1, 12'h002);
      put(b + 2, {7'h01, r});
      put(b + 3, {7'h1b, r});
      put(b + 4, {7'h1a, r});
      put(b + 5, {4'h8, 8'($urandom)});
      put(a + 1, 12'hfff);
      put(a + 2, {7'h1a, r});
      repeat (5) @(negedge i_ref_clk);
      {i_sys_rst, i_push_valid, i_push_addr} = {2'b01, a};
      @(negedge i_ref_clk) i_push_addr = b;
      @(negedge i_ref_clk) i_push_valid = 0;
      repeat (30) @(negedge i_ref_clk);
    end
    tally_and_finish();
  end
endmodule
bind mies_core mies_core_asserts mies_core_asserts_i (.i_ref_clk,
  .i_sys_rst, .i_insn, .o_fetch_discard, .o_pc, .o_acc, .o_cfg, .o_status);
`default_nettype wire
